// ---- logic/phsf_top.sv ----
// Prefetch hint execution and store ordering barrier
`timescale 1ns/10ps
// Operation
// RL1: Prefetch requests aligned 32-byte chunk holding byte
// RL2: Level one nearest, hint selects fill level
// RL3: All-levels hint fills every cache level
// RL4: Second-tier hints fill level two upward only
// RL5: Non-temporal hint fills near, minimal displacement
// RL6: Non-temporal lines keep pollution-limiting marking
// RL7: Closer-level hit suppresses fill entirely
// RL8: Prefetch changes no architectural result
// RL9: Older stores visible before younger stores
// RL10: Non-temporal stores write-combine, never allocate
// RL11: Barrier never holds loads
module phsf_top (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Issue stage
   input wire logic issue_valid,
   output logic issue_ready,
   input wire logic [2:0] issue_op,
   input wire logic [phsf_pkg::ADDR_W-1:0] issue_addr,
   input wire logic [phsf_pkg::DATA_W-1:0] issue_data,
   // Cache presence lookup, same cycle as issue
   input wire logic [2:0] hit_levels,
   // Prefetch fill request to cache hierarchy
   output logic pf_valid,
   input wire logic pf_ready,
   output logic [phsf_pkg::ADDR_W-1:0] pf_addr,
   output logic [2:0] pf_levels,
   output logic pf_nt,
   // Load pass-through
   output logic ld_valid,
   output logic [phsf_pkg::ADDR_W-1:0] ld_addr,
   // Store path to memory
   output logic st_valid,
   input wire logic st_ready,
   output logic [phsf_pkg::ADDR_W-1:0] st_addr,
   output logic [phsf_pkg::DATA_W-1:0] st_data,
   output logic st_wc,
   output logic st_no_alloc,
   input wire logic st_visible,
   // Status
   output logic fence_busy
);
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [phsf_pkg::ADDR_W-1:0] chunk_base(
      input logic [phsf_pkg::ADDR_W-1:0] a);
      chunk_base = {a[phsf_pkg::ADDR_W-1:phsf_pkg::CHUNK_LSB],
         {phsf_pkg::CHUNK_LSB{1'b0}}};
   endfunction

   function automatic logic [2:0] hint_levels(input logic [2:0] op);
      case (op)
         phsf_pkg::OP_PF_ALL: hint_levels = phsf_pkg::LVL_ALL;
         phsf_pkg::OP_PF_T1: hint_levels = phsf_pkg::LVL_L2_UP;
         phsf_pkg::OP_PF_T2: hint_levels = phsf_pkg::LVL_L2_UP;
         phsf_pkg::OP_PF_NTA: hint_levels = phsf_pkg::LVL_NEAR;
         default: hint_levels = phsf_pkg::LVL_NONE;
      endcase
   endfunction

   // Lowest set bit of the target mask is the nearest hinted level
   function automatic logic closer_hit(input logic [2:0] tgt,
      input logic [2:0] hit);
      logic r;
      r = 1'b0;
      if (tgt[2] && !tgt[1] && !tgt[0] && (hit[1] || hit[0]))
         r = 1'b1;
      if (tgt[1] && !tgt[0] && hit[0])
         r = 1'b1;
      if (tgt[0] && hit[0])
         r = 1'b1;
      closer_hit = r;
   endfunction

   // ****************************************
   // Decode
   // ****************************************
   logic is_pf, is_st, is_bar, is_ld, pf_skip;
   logic [2:0] tgt;
   phsf_sq_if sq ();
   logic [phsf_pkg::SQ_CNT_W-1:0] sent_reg, sent_next;
   phsf_pkg::phsf_fence_e fence_reg, fence_next;
   logic pf_valid_reg, pf_valid_next, pf_nt_reg, pf_nt_next;
   logic [phsf_pkg::ADDR_W-1:0] pf_addr_reg, pf_addr_next;
   logic [2:0] pf_lvl_reg, pf_lvl_next;
   logic ld_valid_reg, ld_valid_next;
   logic [phsf_pkg::ADDR_W-1:0] ld_addr_reg, ld_addr_next;
   logic st_block, accept;

   assign tgt = hint_levels(issue_op);
   assign is_pf = issue_valid && !issue_op[2];
   assign is_st = issue_valid && (issue_op == phsf_pkg::OP_STORE ||
      issue_op == phsf_pkg::OP_STORE_NT);
   assign is_bar = issue_valid && issue_op == phsf_pkg::OP_BARRIER;
   assign is_ld = issue_valid && issue_op == phsf_pkg::OP_LOAD;
   assign pf_skip = closer_hit(tgt, hit_levels); // RL7

   // Younger stores wait while the barrier drains; loads never wait
   assign st_block = (fence_reg == phsf_pkg::PHSF_DRAIN); // RL9

   always_comb begin
      issue_ready = 1'b1; // RL11
      if (is_st)
         issue_ready = !st_block && sq.push_ready; // RL9
      else if (is_pf)
         issue_ready = !pf_valid_reg || pf_ready;
      else if (is_bar)
         issue_ready = !st_block;
   end
   assign accept = issue_valid && issue_ready;

   // ****************************************
   // Store queue and visibility tracking
   // ****************************************
   assign sq.push_valid = is_st && !st_block;
   assign sq.push_addr = issue_addr;
   assign sq.push_data = issue_data;
   assign sq.push_nt = issue_op == phsf_pkg::OP_STORE_NT;
   assign sq.mem_ready = st_ready;

   phsf_store_queue u_sq (
      .clock(clock),
      .nrst(nrst),
      .sq(sq.queue)
   );

   assign st_valid = sq.mem_valid;
   assign st_addr = sq.mem_addr;
   assign st_data = sq.mem_data;
   assign st_wc = sq.mem_nt; // RL10
   assign st_no_alloc = sq.mem_nt; // RL10

   // Sent but not yet acknowledged visible; nt stores may retire unordered
   always_comb begin
      sent_next = sent_reg + 3'(st_valid && st_ready) - 3'(st_visible);
      fence_next = fence_reg;
      case (fence_reg)
         phsf_pkg::PHSF_OPEN:
            if (is_bar)
               fence_next = phsf_pkg::PHSF_DRAIN; // RL9
         phsf_pkg::PHSF_DRAIN:
            if (sq.pending == 3'h0 && sent_reg == 3'h0)
               fence_next = phsf_pkg::PHSF_OPEN; // RL9
         default: fence_next = phsf_pkg::PHSF_OPEN;
      endcase
   end
   assign fence_busy = st_block;

   // ****************************************
   // Prefetch and load outputs
   // ****************************************
   always_comb begin
      pf_valid_next = pf_valid_reg && !pf_ready;
      pf_addr_next = pf_addr_reg;
      pf_lvl_next = pf_lvl_reg;
      pf_nt_next = pf_nt_reg;
      if (is_pf && accept && !pf_skip) begin
         pf_valid_next = 1'b1;
         pf_addr_next = chunk_base(issue_addr); // RL1
         pf_lvl_next = tgt; // RL2 RL3 RL4 RL5
         pf_nt_next = issue_op == phsf_pkg::OP_PF_NTA; // RL6
      end
      ld_valid_next = is_ld; // RL11
      ld_addr_next = is_ld ? issue_addr : ld_addr_reg;
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         fence_reg <= phsf_pkg::PHSF_OPEN;
         sent_reg <= 3'h0;
         pf_valid_reg <= 1'b0;
         pf_addr_reg <= 32'h0000_0000;
         pf_lvl_reg <= 3'h0;
         pf_nt_reg <= 1'b0;
         ld_valid_reg <= 1'b0;
         ld_addr_reg <= 32'h0000_0000;
      end else begin
         fence_reg <= fence_next;
         sent_reg <= sent_next;
         pf_valid_reg <= pf_valid_next;
         pf_addr_reg <= pf_addr_next;
         pf_lvl_reg <= pf_lvl_next;
         pf_nt_reg <= pf_nt_next;
         ld_valid_reg <= ld_valid_next;
         ld_addr_reg <= ld_addr_next;
      end
   end

   // Prefetch path has no write port into any data state
   assign pf_valid = pf_valid_reg; // RL8
   assign pf_addr = pf_addr_reg;
   assign pf_levels = pf_lvl_reg;
   assign pf_nt = pf_nt_reg;
   assign ld_valid = ld_valid_reg;
   assign ld_addr = ld_addr_reg;

   // ****************************************
   // Checks
   // ****************************************
   property p_align;
      @(posedge clock) disable iff (!nrst)
      pf_valid |-> pf_addr[4:0] == 5'h00;
   endproperty
   a_align: assert property (p_align) else $error("Chunk misaligned"); // RL1

   property p_lvl_all;
      @(posedge clock) disable iff (!nrst)
      (accept && issue_op == phsf_pkg::OP_PF_ALL && !pf_skip)
         |=> pf_valid && pf_levels == 3'h7;
   endproperty
   a_lvl_all: assert property (p_lvl_all) else $error("All-level fill"); // RL3

   property p_lvl_t;
      @(posedge clock) disable iff (!nrst)
      (accept && (issue_op == phsf_pkg::OP_PF_T1 ||
         issue_op == phsf_pkg::OP_PF_T2) && !pf_skip)
         |=> pf_valid && pf_levels == 3'h6;
   endproperty
   a_lvl_t: assert property (p_lvl_t) else $error("Tier two fill"); // RL4

   property p_nta;
      @(posedge clock) disable iff (!nrst)
      (accept && issue_op == phsf_pkg::OP_PF_NTA && !pf_skip)
         |=> pf_nt && pf_levels == 3'h1;
   endproperty
   a_nta: assert property (p_nta) else $error("Non-temporal fill"); // RL5

   property p_skip;
      @(posedge clock) disable iff (!nrst)
      (is_pf && accept && pf_skip && !pf_valid) |=> !pf_valid;
   endproperty
   a_skip: assert property (p_skip) else $error("Fill despite hit"); // RL7

   property p_hold;
      @(posedge clock) disable iff (!nrst)
      (fence_busy && (sq.pending != 3'h0 || sent_reg != 3'h0))
         |-> !sq.push_valid ##1 fence_busy;
   endproperty
   a_hold: assert property (p_hold) else $error("Store passed barrier"); // RL9

   property p_wc;
      @(posedge clock) disable iff (!nrst)
      (accept && issue_op == phsf_pkg::OP_STORE_NT && sq.pending == 3'h0)
         |=> st_valid && st_wc && st_no_alloc;
   endproperty
   a_wc: assert property (p_wc) else $error("WC store allocates"); // RL10

   property p_load;
      @(posedge clock) disable iff (!nrst)
      (is_ld && fence_busy) |-> issue_ready ##1 ld_valid;
   endproperty
   a_load: assert property (p_load) else $error("Load held"); // RL11
endmodule // phsf_top

// ---- logic/phsf_pkg.sv ----
// Package of constants and types for the prefetch hint and store fence block
package phsf_pkg;
   // ****************************************
   // Widths
   // ****************************************
   localparam int ADDR_W = 32;
   localparam int DATA_W = 64;
   localparam int CHUNK_BYTES = 32;
   localparam int CHUNK_LSB = $clog2(CHUNK_BYTES);
   localparam int SQ_DEPTH = 4;
   localparam int SQ_PTR_W = 2;
   localparam int SQ_CNT_W = 3;
   // ****************************************
   // Operation codes from issue
   // ****************************************
   localparam logic [2:0] OP_PF_ALL = 3'h0;
   localparam logic [2:0] OP_PF_T1 = 3'h1;
   localparam logic [2:0] OP_PF_T2 = 3'h2;
   localparam logic [2:0] OP_PF_NTA = 3'h3;
   localparam logic [2:0] OP_STORE = 3'h4;
   localparam logic [2:0] OP_STORE_NT = 3'h5;
   localparam logic [2:0] OP_BARRIER = 3'h6;
   localparam logic [2:0] OP_LOAD = 3'h7;
   // ****************************************
   // Fill level masks: bit0 first level, bit1 second level, bit2 outer
   // ****************************************
   localparam logic [2:0] LVL_ALL = 3'h7;
   localparam logic [2:0] LVL_L2_UP = 3'h6;
   localparam logic [2:0] LVL_NEAR = 3'h1;
   localparam logic [2:0] LVL_NONE = 3'h0;
   // ****************************************
   // Barrier state machine
   // ****************************************
   typedef enum logic [1:0] {
      PHSF_OPEN = 2'b01,
      PHSF_DRAIN = 2'b10
   } phsf_fence_e;
endpackage

// ---- logic/phsf_sq_if.sv ----
// Interface carrying store queue requests and memory drain handshake
`timescale 1ns/10ps
interface phsf_sq_if;
   logic push_valid;
   logic push_ready;
   logic [phsf_pkg::ADDR_W-1:0] push_addr;
   logic [phsf_pkg::DATA_W-1:0] push_data;
   logic push_nt;
   logic mem_valid;
   logic mem_ready;
   logic [phsf_pkg::ADDR_W-1:0] mem_addr;
   logic [phsf_pkg::DATA_W-1:0] mem_data;
   logic mem_nt;
   logic [phsf_pkg::SQ_CNT_W-1:0] pending;
   modport queue (input push_valid, push_addr, push_data, push_nt,
      output push_ready, input mem_ready,
      output mem_valid, mem_addr, mem_data, mem_nt, pending);
   modport ctrl (output push_valid, push_addr, push_data, push_nt,
      input push_ready, output mem_ready,
      input mem_valid, mem_addr, mem_data, mem_nt, pending);
endinterface

// ---- logic/phsf_store_queue.sv ----
// Store queue holding stores in order until memory accepts them on the ready handshake
`timescale 1ns/10ps
module phsf_store_queue (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Queue side
   phsf_sq_if.queue sq
);
   logic [phsf_pkg::ADDR_W-1:0] addr_mem [phsf_pkg::SQ_DEPTH];
   logic [phsf_pkg::DATA_W-1:0] data_mem [phsf_pkg::SQ_DEPTH];
   logic nt_mem [phsf_pkg::SQ_DEPTH];
   logic [phsf_pkg::SQ_PTR_W-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [phsf_pkg::SQ_CNT_W-1:0] cnt_reg, cnt_next;
   logic push, pop;

   always_comb begin
      sq.push_ready = (cnt_reg != 3'(phsf_pkg::SQ_DEPTH));
      sq.mem_valid = (cnt_reg != 3'h0);
      sq.mem_addr = addr_mem[rd_reg];
      sq.mem_data = data_mem[rd_reg];
      sq.mem_nt = nt_mem[rd_reg];
      sq.pending = cnt_reg;
      push = sq.push_valid && sq.push_ready;
      pop = sq.mem_valid && sq.mem_ready;
      wr_next = push ? wr_reg + 2'h1 : wr_reg;
      rd_next = pop ? rd_reg + 2'h1 : rd_reg;
      cnt_next = cnt_reg + 3'(push) - 3'(pop);
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         wr_reg <= 2'h0;
         rd_reg <= 2'h0;
         cnt_reg <= 3'h0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
      end
   end

   // Storage has no reset; entries are only read while counted valid
   always_ff @(posedge clock) begin
      if (push) begin
         addr_mem[wr_reg] <= sq.push_addr;
         data_mem[wr_reg] <= sq.push_data;
         nt_mem[wr_reg] <= sq.push_nt;
      end
   end
endmodule // phsf_store_queue

// ---- testbench/phsf_mem_model.sv ----
// Cache hierarchy and memory model facing the prefetch and store ports
`timescale 1ns/10ps
module phsf_mem_model (
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Stall control from the bench
   input wire logic stall,
   // Fill request
   input wire logic pf_valid,
   output logic pf_ready,
   // Store path
   input wire logic st_valid,
   output logic st_ready,
   output logic st_visible
);
   // ****************************************
   // Acceptance and delayed visibility
   // ****************************************
   int n;
   int t;
   logic fire;
   assign pf_ready = pf_valid && !stall;
   assign st_ready = !stall;
   // Acks come late on purpose so a barrier has to wait for them
   assign fire = (n != 0) && (t == 3);
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         n <= 0;
         t <= 0;
         st_visible <= 1'b0;
      end else begin
         st_visible <= fire;
         // Restart the delay while idle so the next store is seen in time
         t <= (fire || n == 0) ? 0 : t + 1;
         n <= n + ((st_valid && st_ready) ? 1 : 0) - (fire ? 1 : 0);
      end
   end
endmodule // phsf_mem_model

// ---- testbench/tb.sv ----
// Self-checking bench for the prefetch hint and store fence block
`timescale 1ns/10ps
module tb;
   // ****************************************
   // Signals
   // ****************************************
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic issue_valid = 1'b0;
   logic issue_ready;
   logic [2:0] issue_op = 3'h0;
   logic [31:0] issue_addr = 32'h0000_0000;
   logic [63:0] issue_data = 64'h0000_0000_0000_0000;
   logic [2:0] hit_levels = 3'h0;
   logic pf_valid, pf_ready, pf_nt, ld_valid, st_valid, st_ready;
   logic st_wc, st_no_alloc, st_visible, fence_busy, stall = 1'b1;
   logic [31:0] pf_addr, ld_addr, st_addr;
   logic [2:0] pf_levels;
   logic [63:0] st_data;
   logic [33:0] log_q [$];
   logic ok;
   int failures = 0;
   int comparisons = 0;
   logic [2:0] r_op [9] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h0, 3'h1, 3'h3,
      3'h2, 3'h0};
   logic [2:0] r_hit [9] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h1,
      3'h2, 3'h4};
   logic [2:0] r_lvl [9] = '{3'h7, 3'h6, 3'h6, 3'h1, 3'h0, 3'h0, 3'h0,
      3'h6, 3'h7};
   logic [31:0] r_addr [9] = '{32'h0000_1234, 32'h0000_2047,
      32'h0000_305f, 32'h0000_40a1, 32'h0000_5000, 32'h0000_6000,
      32'h0000_7000, 32'h0000_8000, 32'h0000_9000};
   always #10 clock = !clock;
   phsf_top dut (.clock(clock), .nrst(nrst), .issue_valid(issue_valid),
      .issue_ready(issue_ready), .issue_op(issue_op),
      .issue_addr(issue_addr), .issue_data(issue_data),
      .hit_levels(hit_levels), .pf_valid(pf_valid), .pf_ready(pf_ready),
      .pf_addr(pf_addr), .pf_levels(pf_levels), .pf_nt(pf_nt),
      .ld_valid(ld_valid), .ld_addr(ld_addr), .st_valid(st_valid),
      .st_ready(st_ready), .st_addr(st_addr), .st_data(st_data),
      .st_wc(st_wc), .st_no_alloc(st_no_alloc), .st_visible(st_visible),
      .fence_busy(fence_busy));
   phsf_mem_model mem (.clock(clock), .nrst(nrst), .stall(stall),
      .pf_valid(pf_valid), .pf_ready(pf_ready), .st_valid(st_valid),
      .st_ready(st_ready), .st_visible(st_visible));
   // Log every store handed to memory, in the order it leaves
   // Sampled just after the falling edge, so the queue update cannot race
   always @(negedge clock) begin
      #1;
      if (st_valid === 1'b1 && st_ready === 1'b1)
         log_q.push_back({st_wc, st_no_alloc, st_addr});
   end
   // ****************************************
   // Tasks
   // ****************************************
   task automatic chk(input string nm, input logic [63:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic iss(input logic [2:0] op, input logic [31:0] a,
         input logic [2:0] hit);
      @(negedge clock);
      issue_valid = 1'b1;
      issue_op = op;
      issue_addr = a;
      issue_data = {a, ~a};
      hit_levels = hit;
      #1 ok = issue_ready;
      @(negedge clock);
      issue_valid = 1'b0;
      hit_levels = 3'h0;
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #400000;
      failures++;
      report_and_stop();
   end
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (5) @(posedge clock);
      chk("rst_pf", pf_valid, 1'b0);
      chk("rst_st", st_valid, 1'b0);
      chk("rst_fence", fence_busy, 1'b0);
      @(negedge clock);
      nrst = 1'b1;
      stall = 1'b0;
      $display("test reset done");
      for (int i = 0; i < 9; i++) begin
         iss(r_op[i], r_addr[i], r_hit[i]);
         chk("pf_accept", ok, 1'b1);
         chk("pf_valid", pf_valid, r_lvl[i] != 3'h0);
         if (r_lvl[i] != 3'h0) begin
            chk("pf_addr", pf_addr, {r_addr[i][31:5], 5'h00});
            chk("pf_levels", pf_levels, r_lvl[i]);
            chk("pf_nt", pf_nt, r_op[i] == 3'h3);
         end
         chk("pf_no_ld", ld_valid, 1'b0);
         chk("pf_no_st", st_valid, 1'b0);
      end
      $display("test prefetch table done");
      @(negedge clock);
      stall = 1'b1;
      iss(phsf_pkg::OP_PF_ALL, 32'h0000_a040, 3'h0);
      chk("pf_first", ok, 1'b1);
      iss(phsf_pkg::OP_PF_T1, 32'h0000_b000, 3'h0);
      chk("pf_refused", ok, 1'b0);
      chk("pf_hold", pf_addr, 32'h0000_a040);
      for (int i = 0; i < 4; i++) begin
         iss(i == 0 ? phsf_pkg::OP_STORE_NT : phsf_pkg::OP_STORE,
            32'h0000_0100 + 32'(8 * i), 3'h0);
         chk("st_accept", ok, 1'b1);
      end
      iss(phsf_pkg::OP_STORE, 32'h0000_0120, 3'h0);
      chk("st_full", ok, 1'b0);
      iss(phsf_pkg::OP_BARRIER, 32'h0000_0000, 3'h0);
      chk("fence_on", fence_busy, 1'b1);
      iss(phsf_pkg::OP_STORE, 32'h0000_0200, 3'h0);
      chk("st_held", ok, 1'b0);
      iss(phsf_pkg::OP_LOAD, 32'h0000_0300, 3'h0);
      chk("ld_pass", ok, 1'b1);
      chk("ld_valid", ld_valid, 1'b1);
      chk("ld_addr", ld_addr, 32'h0000_0300);
      stall = 1'b0;
      for (int i = 0; i < 300 && fence_busy !== 1'b0; i++)
         @(negedge clock);
      chk("fence_off", fence_busy, 1'b0);
      chk("st_count", log_q.size(), 4);
      for (int i = 0; i < 4 && i < log_q.size(); i++)
         chk("st_order", log_q[i], {i == 0, i == 0,
            32'h0000_0100 + 32'(8 * i)});
      iss(phsf_pkg::OP_STORE, 32'h0000_0200, 3'h0);
      chk("st_after", ok, 1'b1);
      chk("st_data", st_data, {32'h0000_0200, ~32'h0000_0200});
      repeat (3) @(negedge clock);
      chk("st_last", log_q[log_q.size() - 1], {2'b00, 32'h0000_0200});
      $display("test barrier done");
      report_and_stop();
   end
endmodule // tb
